/* logic/fmt_pkg.sv */
// Operation
// - Keep a 16-bit decoder error count, read as low then high byte.
// - The clear-error control bit resets the error count to zero, or to the error number of a block reported in the same cycle.
// - Four output modes: gapped or gap-free, each parallel or serial.
// - Gap-free mode spreads idle time evenly, words at a uniform rate.
// - Frame-start output is low with the first byte of each frame.
// - Gap-free parallel: 188 bytes, one per clock, clock high half period.
// - Gap-free serial: 8 x 188 bits, one clock period per bit.
// - Gapped parallel: each output clock is a short strobe of 10 ns, 8 ns rounded up to whole 5 ns clocks.
// - Gapped parallel: 188 bytes, then data and clock idle until next frame.
// - Gapped serial: exactly 8 x 188 clocks and bits per frame start.
// - Gap-bypass bit 0 selects gap-free timing; bit 1 selects gapped timing.
// - Serial-select bit 1 gives bit-serial data, otherwise parallel bytes.
package fmt_pkg;
   localparam logic [7:0] OFF_CODE_CFG = 8'h70;
   localparam logic [7:0] OFF_RATE = 8'h71;
   localparam logic [7:0] OFF_ERR_LO = 8'h72;
   localparam logic [7:0] OFF_ERR_HI = 8'h73;
   localparam logic [7:0] OFF_ERR_CLR = 8'h74;
   localparam logic [7:0] OFF_MODE = 8'h75;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h76;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h77;
   localparam logic [7:0] OFF_IRQ_EN = 8'h78;

   localparam int MODE_SERIAL_BIT = 0;
   localparam int MODE_BYPASS_BIT = 1;
   localparam int ERR_CLR_BIT = 0;
   localparam int IRQ_FRAME_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam int IRQ_STALL_BIT = 2;

   localparam logic [7:0] CODE_CFG_RST = 8'h00;
   localparam logic [4:0] RATE_RST = 5'h10;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [2:0] IRQ_EN_RST = 3'h0;

   localparam int CLK_NS = 5;
   localparam int STROBE_NS = 8;
   localparam logic [4:0] STROBE_CYC = 5'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] GAP_SLOT_CYC = 5'(2 * STROBE_CYC);
   localparam logic [4:0] MIN_PERIOD = 5'h02;

   localparam int FRAME_BYTES = 188;
   localparam logic [7:0] FRAME_LAST = 8'(FRAME_BYTES - 1);
   localparam logic [2:0] BITS_LAST = 3'h7;
   localparam logic [10:0] PAR_FRAME_CLKS = 11'(FRAME_BYTES);
   localparam logic [10:0] SER_FRAME_CLKS = 11'(8 * FRAME_BYTES);

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic clk;
      logic sync_n;
   } ts_out_t;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_STALL} state_t;
endpackage

/* logic/slot_timer.sv */
module slot_timer (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // slot control
   input wire logic run_in,
   input wire logic [4:0] period_in,
   input wire logic [4:0] high_in,
   // slot state
   output logic slot_end_out,
   output logic clk_lvl_out
);
   logic [4:0] cnt;

   assign slot_end_out = run_in && (cnt == period_in - 5'h01);
   assign clk_lvl_out = run_in && (cnt < high_in);

   // held at zero while stopped, so a restart always begins a full slot
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt <= 5'h00;
      end else if (!run_in || slot_end_out) begin
         cnt <= 5'h00;
      end else begin
         cnt <= cnt + 5'h01;
      end
   end
endmodule

/* logic/err_counter.sv */
module err_counter (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // control and events
   input wire logic clear_in,
   input wire logic add_valid_in,
   input wire logic [7:0] add_in,
   // count
   output logic [15:0] count_out
);
   logic [15:0] base;
   logic [16:0] sum;

   // clear and add together: the new block is kept, not lost
   assign base = clear_in ? 16'h0000 : count_out;
   assign sum = {1'b0, base} + {9'h000, add_in};

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count_out <= 16'h0000;
      end else if (add_valid_in) begin
         // saturate rather than wrap, a wrapped count reads as healthy
         count_out <= sum[16] ? 16'hffff : sum[15:0];
      end else if (clear_in) begin
         count_out <= 16'h0000;
      end
   end
endmodule

/* logic/qam_output_formatter.sv */
// Implementation choice: the strobed register port.
module qam_output_formatter (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // register port
   input wire fmt_pkg::reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   // decoded frame stream
   input wire logic [7:0] rx_data_in,
   input wire logic rx_valid_in,
   input wire logic rx_sof_in,
   output logic rx_ready_out,
   // decoder block error report
   input wire logic blk_err_valid_in,
   input wire logic [7:0] blk_err_num_in,
   // transport output and interrupt
   output fmt_pkg::ts_out_t ts_out,
   output logic irq_out
);
   logic [7:0] code_cfg;
   logic [4:0] rate;
   logic [1:0] mode;
   logic [2:0] irq_en;
   logic [2:0] irq_stat;
   logic [15:0] err_count;
   fmt_pkg::state_t state;
   fmt_pkg::state_t next_state;
   logic [7:0] shreg;
   logic [7:0] bytes_left;
   logic [2:0] bits_left;
   logic sync_n_int;
   fmt_pkg::ts_out_t next_ts;
   fmt_pkg::ts_out_t ts_q_o;
   logic [7:0] rd_mux;
   logic slot_end;
   logic clk_lvl;

   // register decode
   wire [7:0] addr = reg_req_in.addr;
   wire [7:0] wdata = reg_req_in.wdata;
   wire wr_code = reg_req_in.wr && (addr == fmt_pkg::OFF_CODE_CFG);
   wire wr_rate = reg_req_in.wr && (addr == fmt_pkg::OFF_RATE);
   wire wr_clr = reg_req_in.wr && (addr == fmt_pkg::OFF_ERR_CLR);
   wire wr_mode = reg_req_in.wr && (addr == fmt_pkg::OFF_MODE);
   wire wr_iclr = reg_req_in.wr && (addr == fmt_pkg::OFF_IRQ_CLR);
   wire wr_ien = reg_req_in.wr && (addr == fmt_pkg::OFF_IRQ_EN);
   wire err_clear = wr_clr && wdata[fmt_pkg::ERR_CLR_BIT];

   // mode decode
   wire serial = mode[fmt_pkg::MODE_SERIAL_BIT];
   wire bypass = mode[fmt_pkg::MODE_BYPASS_BIT];

   // slot timing; a rate below two cannot make a half-period clock
   wire [4:0] rate_period =
      (rate < fmt_pkg::MIN_PERIOD) ? fmt_pkg::MIN_PERIOD : rate;
   wire [4:0] slot_period =
      bypass ? fmt_pkg::GAP_SLOT_CYC : rate_period;
   wire [4:0] slot_high =
      bypass ? fmt_pkg::STROBE_CYC : (rate_period >> 1);

   // frame sequencing
   wire idle = (state == fmt_pkg::ST_IDLE);
   wire sending = (state == fmt_pkg::ST_SEND);
   wire stalled = (state == fmt_pkg::ST_STALL);
   wire last_bit = !serial || (bits_left == 3'h0);
   wire word_end = sending && slot_end && last_bit;
   wire need_byte = word_end && (bytes_left != 8'h00);
   wire frame_done = word_end && (bytes_left == 8'h00);
   wire shift_bit = sending && slot_end && !last_bit;
   wire take = rx_ready_out && rx_valid_in;
   wire start_frame = idle && take && rx_sof_in;
   wire load_next = take && !idle;
   wire load_word = start_frame || load_next;
   wire stall_enter = need_byte && !rx_valid_in;
   wire [2:0] irq_ev = {stall_enter,
                        blk_err_valid_in && (blk_err_num_in != 8'h00),
                        frame_done};
   wire [2:0] irq_clr_mask = wr_iclr ? wdata[2:0] : 3'h0;

   // bytes without a frame start are dropped while idle
   assign rx_ready_out = idle || stalled || need_byte;
   assign irq_out = |(irq_stat & irq_en);
   assign ts_out = ts_q_o;

   slot_timer u_slot_timer (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .run_in(sending),
      .period_in(slot_period),
      .high_in(slot_high),
      .slot_end_out(slot_end),
      .clk_lvl_out(clk_lvl)
   );

   err_counter u_err_counter (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .clear_in(err_clear),
      .add_valid_in(blk_err_valid_in),
      .add_in(blk_err_num_in),
      .count_out(err_count)
   );

   always_comb begin
      next_state = state;
      case (state)
         fmt_pkg::ST_IDLE: begin
            if (start_frame) begin
               next_state = fmt_pkg::ST_SEND;
            end
         end
         fmt_pkg::ST_SEND: begin
            if (frame_done) begin
               next_state = fmt_pkg::ST_IDLE;
            end else if (stall_enter) begin
               next_state = fmt_pkg::ST_STALL;
            end
         end
         fmt_pkg::ST_STALL: begin
            if (take) begin
               next_state = fmt_pkg::ST_SEND;
            end
         end
         default: next_state = fmt_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= fmt_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // word shifter and frame counters
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shreg <= 8'h00;
         bits_left <= 3'h0;
      end else if (load_word) begin
         shreg <= rx_data_in;
         bits_left <= serial ? fmt_pkg::BITS_LAST : 3'h0;
      end else if (shift_bit) begin
         shreg <= {shreg[6:0], 1'b0};
         bits_left <= bits_left - 3'h1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bytes_left <= 8'h00;
         sync_n_int <= 1'b1;
      end else if (start_frame) begin
         bytes_left <= fmt_pkg::FRAME_LAST;
         sync_n_int <= 1'b0;
      end else if (load_next || frame_done) begin
         bytes_left <= bytes_left - {7'h00, load_next};
         sync_n_int <= 1'b1;
      end
   end

   // outputs trail the shifter by one cycle, so data and clock change on the same edge
   always_comb begin
      next_ts.data = 8'h00;
      if (!idle) begin
         next_ts.data = serial ? {7'h00, shreg[7]} : shreg;
      end
      next_ts.clk = clk_lvl;
      next_ts.sync_n = sync_n_int;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ts_q_o <= '{data: 8'h00, clk: 1'b0, sync_n: 1'b1};
      end else begin
         ts_q_o <= next_ts;
      end
   end

   // software registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         code_cfg <= fmt_pkg::CODE_CFG_RST;
         rate <= fmt_pkg::RATE_RST;
         mode <= fmt_pkg::MODE_RST;
         irq_en <= fmt_pkg::IRQ_EN_RST;
      end else begin
         if (wr_code) begin
            code_cfg <= wdata;
         end
         if (wr_rate) begin
            rate <= wdata[4:0];
         end
         if (wr_mode) begin
            mode <= wdata[1:0];
         end
         if (wr_ien) begin
            irq_en <= wdata[2:0];
         end
      end
   end

   // a new event beats a clear in the same cycle
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_stat <= 3'h0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr_mask) | irq_ev;
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      if (addr == fmt_pkg::OFF_CODE_CFG) begin
         rd_mux = code_cfg;
      end else if (addr == fmt_pkg::OFF_RATE) begin
         rd_mux = {3'h0, rate};
      end else if (addr == fmt_pkg::OFF_ERR_LO) begin
         rd_mux = err_count[7:0];
      end else if (addr == fmt_pkg::OFF_ERR_HI) begin
         rd_mux = err_count[15:8];
      end else if (addr == fmt_pkg::OFF_MODE) begin
         rd_mux = {6'h00, mode};
      end else if (addr == fmt_pkg::OFF_IRQ_STAT) begin
         rd_mux = {5'h00, irq_stat};
      end else if (addr == fmt_pkg::OFF_IRQ_EN) begin
         rd_mux = {5'h00, irq_en};
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= reg_req_in.rd ? rd_mux : 8'h00;
      end
   end

   // checking helpers: clock edges, spacing and per-frame pulse count
   logic clk_prev;
   logic steady;
   logic [7:0] gap;
   logic [7:0] hi;
   logic [10:0] rises;
   wire rise = ts_q_o.clk && !clk_prev;
   wire fall = !ts_q_o.clk && clk_prev;
   wire [10:0] frame_clks =
      serial ? fmt_pkg::SER_FRAME_CLKS : fmt_pkg::PAR_FRAME_CLKS;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clk_prev <= 1'b0;
         steady <= 1'b0;
         gap <= 8'h00;
         hi <= 8'h00;
         rises <= 11'h000;
      end else begin
         clk_prev <= ts_q_o.clk;
         steady <= rise ? 1'b1 : (sending ? steady : 1'b0);
         gap <= rise ? 8'h01 : gap + 8'h01;
         hi <= ts_q_o.clk ? hi + 8'h01 : 8'h00;
         rises <= start_frame ? 11'h000 : rises + {10'h000, rise};
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   AST_SYNC_FIRST: assert property (
      $fell(ts_q_o.sync_n) |-> $past(start_frame, 2))
      else $error("frame start not aligned with first byte");

   AST_ERR_CLEAR: assert property (
      err_clear && !blk_err_valid_in |=> err_count == 16'h0000)
      else $error("error count not cleared");

   AST_ERR_READ: assert property (
      reg_req_in.rd && addr == fmt_pkg::OFF_ERR_HI
      |=> reg_rdata_out == $past(err_count[15:8]))
      else $error("error count high byte read wrong");

   AST_GAPFREE_RATE: assert property (
      rise && steady && !bypass |-> gap == {3'h0, slot_period})
      else $error("gap-free clock period not uniform");

   AST_HALF_HIGH: assert property (
      fall && steady && !bypass |-> hi == {3'h0, rate_period >> 1})
      else $error("gap-free clock high time not half period");

   AST_STROBE: assert property (
      $rose(ts_q_o.clk) && bypass |-> ##1 ts_q_o.clk ##1 !ts_q_o.clk)
      else $error("gapped strobe width wrong");

   AST_FRAME_CLOCKS: assert property (
      frame_done |=> rises == frame_clks)
      else $error("wrong number of clocks in frame");

   AST_IDLE_QUIET: assert property (
      idle && $past(idle) |-> !ts_q_o.clk && ts_q_o.data == 8'h00)
      else $error("output active between frames");

   AST_SERIAL_LINE: assert property (
      $past(serial) |-> ts_q_o.data[7:1] == 7'h00)
      else $error("serial mode drives parallel lanes");
endmodule

/* tb/ts_consumer.sv */
module ts_consumer (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // observation control
   input wire logic serial_in,
   input wire logic restart_in,
   input wire fmt_pkg::ts_out_t ts_in,
   // observations
   output logic [10:0] pulses_out,
   output logic [7:0] byte_out,
   output logic byte_stb_out,
   output logic [4:0] high_out,
   output logic [5:0] period_out,
   output logic [7:0] sync_err_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_clk;
   logic [4:0] hi_run;
   logic [5:0] per_run;
   logic [7:0] shreg;
   wire logic rise = ts_in.clk & ~prev_clk;
   wire logic [7:0] next_shreg = {shreg[6:0], ts_in.data[0]};
   // serial frames keep the start marker low for the whole first byte
   wire logic is_first = serial_in ? (pulses_out < 11'h008) :
      (pulses_out == 11'h000);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prev_clk <= 1'b0;
         hi_run <= 5'h00;
         per_run <= 6'h00;
         shreg <= 8'h00;
         pulses_out <= 11'h000;
         byte_out <= 8'h00;
         byte_stb_out <= 1'b0;
         high_out <= 5'h00;
         period_out <= 6'h00;
         sync_err_out <= 8'h00;
      end else begin
         prev_clk <= ts_in.clk;
         hi_run <= ts_in.clk ? hi_run + 5'h01 : 5'h00;
         if (prev_clk & ~ts_in.clk) high_out <= hi_run;
         per_run <= rise ? 6'h01 : per_run + 6'h01;
         if (rise) period_out <= per_run;
         byte_stb_out <= 1'b0;
         if (restart_in) begin
            pulses_out <= 11'h000;
            sync_err_out <= 8'h00;
         end else if (rise) begin
            pulses_out <= pulses_out + 11'h001;
            // saturate so a wrap cannot hide marker errors
            if (ts_in.sync_n == is_first && sync_err_out != 8'hff)
               sync_err_out <= sync_err_out + 8'h01;
            shreg <= next_shreg;
            if (!serial_in) begin
               byte_out <= ts_in.data;
               byte_stb_out <= 1'b1;
            end else if (pulses_out[2:0] == 3'h7) begin
               byte_out <= next_shreg;
               byte_stb_out <= 1'b1;
            end
         end
      end
   end
endmodule

/* tb/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, nrst_in, rx_valid, rx_sof, rx_ready, blk_err_valid, irq;
   logic serial, restart, obs_stb;
   fmt_pkg::reg_req_t reg_req;
   fmt_pkg::ts_out_t ts;
   logic [7:0] reg_rdata, rx_data, blk_err_num, obs_byte, sync_errs, d;
   logic [10:0] pulses;
   logic [4:0] obs_high;
   logic [5:0] obs_period;
   logic [15:0] err_sum;
   logic stall_exp;
   logic [7:0] exp_q[$];
   logic [7:0] offs[9] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76,
      8'h78, 8'h7f};
   logic [7:0] rstv[9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
   int error_cnt = 0;
   int n_checks = 0;
   int seed = 16;

   qam_output_formatter i_qam_output_formatter (.clk_in(clk_in),
      .nrst_in(nrst_in), .reg_req_in(reg_req), .reg_rdata_out(reg_rdata),
      .rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_sof_in(rx_sof),
      .rx_ready_out(rx_ready), .blk_err_valid_in(blk_err_valid),
      .blk_err_num_in(blk_err_num), .ts_out(ts), .irq_out(irq));
   ts_consumer i_ts_consumer (.clk_in(clk_in), .nrst_in(nrst_in),
      .serial_in(serial), .restart_in(restart), .ts_in(ts),
      .pulses_out(pulses), .byte_out(obs_byte), .byte_stb_out(obs_stb),
      .high_out(obs_high), .period_out(obs_period), .sync_err_out(sync_errs));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
         input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_in) reg_req <= {a, v, 1'b1, 1'b0};
      @(posedge clk_in) reg_req <= '0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in) reg_req <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_in) reg_req <= '0;
      @(negedge clk_in) v = reg_rdata;
   endtask

   function automatic logic [15:0] sat_add(logic [15:0] a, logic [7:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {9'h000, b};
      return s[16] ? 16'hffff : s[15:0];
   endfunction

   task automatic err_pulse(input logic [7:0] num);
      @(posedge clk_in) begin
         blk_err_valid <= 1'b1;
         blk_err_num <= num;
      end
      @(posedge clk_in) begin
         blk_err_valid <= 1'b0;
         blk_err_num <= ~num;
      end
      err_sum = sat_add(err_sum, num);
   endtask

   task automatic chk_count();
      logic [7:0] lo, hi;
      reg_rd(fmt_pkg::OFF_ERR_LO, lo);
      reg_rd(fmt_pkg::OFF_ERR_HI, hi);
      chk({hi, lo}, err_sum, "error count");
   endtask

   // source holds each byte until the formatter takes it
   task automatic send_frame(input logic gaps);
      logic [7:0] b;
      logic t;
      for (int i = 0; i < fmt_pkg::FRAME_BYTES; i++) begin
         b = 8'($random(seed));
         exp_q.push_back(b);
         rx_data <= b;
         rx_sof <= (i == 0);
         rx_valid <= 1'b1;
         t = 1'b0;
         while (!t) begin
            @(negedge clk_in) t = rx_ready;
            @(posedge clk_in);
         end
         if (gaps && b[1:0] == 2'h0) begin
            rx_valid <= 1'b0;
            rx_data <= ~b;
            // a pause of at least one slot stalls a parallel frame
            if (!serial && i < fmt_pkg::FRAME_BYTES - 1 &&
                  3 + b[3:2] >= fmt_pkg::GAP_SLOT_CYC) stall_exp = 1'b1;
            repeat (3 + b[3:2]) @(posedge clk_in);
         end
      end
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_data <= 8'h5a;
   endtask

   task automatic run_mode(input logic [1:0] mode);
      logic [10:0] n;
      reg_wr(fmt_pkg::OFF_MODE, {6'h00, mode});
      reg_wr(fmt_pkg::OFF_IRQ_CLR, 8'h07);
      stall_exp = 1'b0;
      n = mode[0] ? fmt_pkg::SER_FRAME_CLKS : fmt_pkg::PAR_FRAME_CLKS;
      @(posedge clk_in) begin
         serial <= mode[0];
         restart <= 1'b1;
      end
      @(posedge clk_in) restart <= 1'b0;
      send_frame(mode[1]);
      for (int w = 0; w < 40000 && pulses !== n; w++) @(negedge clk_in);
      repeat (40) @(negedge clk_in);
      chk(16'(pulses), 16'(n), "clock pulses per frame");
      chk(16'(sync_errs), 16'h0000, "frame start marker");
      chk(16'(exp_q.size()), 16'h0000, "bytes left unsent");
      if (mode[1]) begin
         chk(16'(obs_high), 16'(fmt_pkg::STROBE_CYC), "strobe");
         chk({7'h00, ts.clk, ts.data}, 16'h0000, "idle after frame");
      end else begin
         chk(16'(obs_high), 16'h0008, "clock high time");
         chk(16'(obs_period), 16'h0010, "slot period");
      end
      reg_rd(fmt_pkg::OFF_IRQ_STAT, d);
      chk(16'(d), {13'h0000, stall_exp, 2'h1}, "frame status");
      $display("frame test in mode %0d done", mode);
   endtask

   always @(negedge clk_in) begin
      if (obs_stb === 1'b1) begin
         if (exp_q.size() == 0) chk(16'h0001, 16'h0000, "extra byte");
         else chk(16'(obs_byte), 16'(exp_q.pop_front()), "data");
      end
   end

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // about 36000 cycles are expected; allow a wide margin
   initial begin
      #300000;
      error_cnt++;
      $display("MISMATCH at %0t: run timed out", $time);
      report_and_stop();
   end

   initial begin
      nrst_in = 1'b0;
      reg_req = '0;
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      blk_err_valid = 1'b0;
      blk_err_num = 8'h00;
      serial = 1'b0;
      restart = 1'b0;
      err_sum = 16'h0000;
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         reg_rd(offs[i], d);
         chk(16'(d), 16'(rstv[i]), "reset value");
      end
      $display("reset value test done");
      reg_wr(fmt_pkg::OFF_CODE_CFG, 8'hcc);
      reg_rd(fmt_pkg::OFF_CODE_CFG, d);
      chk(16'(d), 16'h00cc, "code block config");
      reg_wr(fmt_pkg::OFF_CODE_CFG, 8'h80);
      reg_rd(fmt_pkg::OFF_CODE_CFG, d);
      chk(16'(d), 16'h0080, "code block config");
      reg_wr(fmt_pkg::OFF_RATE, 8'h10);
      reg_rd(fmt_pkg::OFF_RATE, d);
      chk(16'(d), 16'h0010, "rate");
      $display("configuration test done");
      repeat (6) err_pulse(8'($random(seed)));
      chk_count();
      reg_wr(fmt_pkg::OFF_ERR_LO, 8'h55);
      chk_count();
      repeat (260) err_pulse(8'hff);
      chk_count();
      reg_wr(fmt_pkg::OFF_ERR_CLR, 8'h01);
      err_sum = 16'h0000;
      chk_count();
      $display("error counter test done");
      reg_wr(fmt_pkg::OFF_IRQ_CLR, 8'h07);
      err_pulse(8'h03);
      @(negedge clk_in) chk(16'(irq), 16'h0000, "masked interrupt");
      reg_rd(fmt_pkg::OFF_IRQ_STAT, d);
      chk(16'(d[fmt_pkg::IRQ_ERR_BIT]), 16'h0001, "error status");
      reg_wr(fmt_pkg::OFF_IRQ_EN, 8'h02);
      @(negedge clk_in) chk(16'(irq), 16'h0001, "interrupt raised");
      reg_wr(fmt_pkg::OFF_IRQ_CLR, 8'h02);
      @(negedge clk_in) chk(16'(irq), 16'h0000, "interrupt cleared");
      $display("interrupt test done");
      for (int m = 0; m < 4; m++) run_mode(2'(m));
      report_and_stop();
   end
endmodule
